/* rtl/itfd_params.svh */
`ifndef ITFD_PARAMS_SVH
`define ITFD_PARAMS_SVH

// register byte offsets
`define ITFD_OFS_MASK 6'h00
`define ITFD_OFS_FUNC 6'h04
`define ITFD_OFS_CTRL 6'h08
`define ITFD_OFS_STAT 6'h0c
`define ITFD_OFS_CNT 6'h10
`define ITFD_OFS_FREQ 6'h14

// reset values
`define ITFD_MASK_RST 12'h000
`define ITFD_FUNC_RST 30'h00000000
`define ITFD_CTRL_RST 4'h0

// field layout
`define ITFD_FUNC_FIELD_W 5
`define ITFD_CTRL_SRC_LSB 0
`define ITFD_CTRL_DIRCFG_BIT 2
`define ITFD_CTRL_MASTER_BIT 3
`define ITFD_STAT_TERM_LSB 18

// terminals that cannot carry trigger, fault or jog
`define ITFD_LOW_TERMS 6'h03
// terminals whose sense is fixed in terminal command mode
`define ITFD_WIRE_TERMS 6'h07

// timing
`define ITFD_CLK_PERIOD_NS 32'h0000000a
`define ITFD_RAMP_PERIOD_NS 32'h00002710
`define ITFD_RAMP_CYCLES (`ITFD_RAMP_PERIOD_NS / `ITFD_CLK_PERIOD_NS)
`define ITFD_FREQ_STEP 16'h0001
`define ITFD_FREQ_MAX 16'hea60

`endif

/* rtl/itfd_pkg.sv */
package itfd_pkg;

  typedef enum logic [4:0] {
    ITFD_FN_NONE = 5'h00,
    ITFD_FN_JOG = 5'h08,
    ITFD_FN_BASE_BLOCK = 5'h09,
    ITFD_FN_FREQ_UP = 5'h0a,
    ITFD_FN_FREQ_DOWN = 5'h0b,
    ITFD_FN_CNT_TRIG = 5'h0c,
    ITFD_FN_CNT_RESET = 5'h0d,
    ITFD_FN_EXT_FAULT = 5'h0e,
    ITFD_FN_PID_OFF = 5'h0f,
    ITFD_FN_SHUTOFF = 5'h10,
    ITFD_FN_PARAM_LOCK = 5'h11,
    ITFD_FN_SRC_TERM = 5'h12,
    ITFD_FN_SRC_KEYPAD = 5'h13,
    ITFD_FN_SRC_COMM = 5'h14,
    ITFD_FN_DIRECTION = 5'h15,
    ITFD_FN_FREQ_SRC2 = 5'h16,
    ITFD_FN_FWD_LIMIT = 5'h17,
    ITFD_FN_REV_LIMIT = 5'h18,
    ITFD_FN_PUMP_AUTO = 5'h19
  } itfd_func_e;

  typedef enum logic [1:0] {
    ITFD_SRC_KEYPAD = 2'h0,
    ITFD_SRC_TERMINAL = 2'h1,
    ITFD_SRC_COMM = 2'h2
  } itfd_cmd_src_e;

  // gray sequence normal -> block -> search -> accel -> normal
  typedef enum logic [1:0] {
    ITFD_BB_NORMAL = 2'h0,
    ITFD_BB_BLOCK = 2'h1,
    ITFD_BB_SEARCH = 2'h3,
    ITFD_BB_ACCEL = 2'h2
  } itfd_bb_state_e;

  typedef struct packed {
    logic outputs_blocked;
    logic speed_search;
    logic accel_to_master;
    logic restart_zero;
    logic jog_req;
    logic ext_fault;
    logic pid_disable;
    logic param_lock;
    itfd_cmd_src_e cmd_src;
    logic freq_src_second;
    logic dir_override;
    logic dir_reverse;
    logic stop_fwd;
    logic stop_rev;
    logic pump_auto;
    logic pump_local_ctrl;
    logic pump_follow_master;
  } itfd_drive_ctrl_s;

  typedef struct packed {
    logic motor_running;
    logic motor_reverse;
    logic speed_locked;
    logic at_master_freq;
  } itfd_drive_state_s;

endpackage

/* rtl/itfd_top.sv */
// What this block does
// - jog assignment accepted only while motor stopped
// - base block active blocks outputs, motor coasts
// - base block release: speed search, then accelerate
// - up/down inputs step and ramp master frequency
// - both up and down active halts frequency
// - counter trigger on terminals 3-6 counts one
// - counter reset holds counter at zero, inhibits counting
// - terminals 3-6 may raise external fault
// - pid-disable input turns pid off
// - shutoff coasts motor, restart from zero after change
// - parameter lock refuses every parameter write
// - terminal source select overrides configured source
// - keypad source select overrides configured source
// - communication source select overrides configured source
// - direction input wins when direction config zero
// - second-source input picks second frequency source
// - forward limit stops forward running
// - reverse limit stops reverse running
// - pump input switches hand and auto mode
// - auto mode: master controls, slaves follow
// - mask bit n sets terminal n+1 normally closed
// - terminal command mode ignores mask for terminals 1-3
// - normally-open terminal activation detected on falling edge
`timescale 1ns/100ps
`default_nettype none
`include "itfd_params.svh"

module itfd_top
  import itfd_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int FREQ_W = 16,
  parameter int RAMP_CYCLES = `ITFD_RAMP_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // terminal pins, low when contact closed to common
  input wire logic input_terminal_1,
  input wire logic input_terminal_2,
  input wire logic input_terminal_3,
  input wire logic input_terminal_4,
  input wire logic input_terminal_5,
  input wire logic input_terminal_6,
  // drive state
  input wire itfd_drive_state_s drive_state,
  // drive control
  output itfd_drive_ctrl_s drive_ctrl,
  output logic [CNT_W-1:0] counter_value,
  output logic [FREQ_W-1:0] master_freq
);

  localparam int CTRL_W = $bits(itfd_drive_ctrl_s);
  localparam int FW = `ITFD_FUNC_FIELD_W;
  localparam logic [5:0] LOW_TERMS = `ITFD_LOW_TERMS;

  // status word packs the control struct below the terminal bits
  generate
    if (CNT_W < 1 || CNT_W > 32 || FREQ_W < 16 || FREQ_W > 32 || RAMP_CYCLES < 1 ||
        CTRL_W != `ITFD_STAT_TERM_LSB)
    begin : g_bad_param
      $error("itfd_top: unsupported parameter value");
    end
  endgenerate

  // terminals whose field holds the given code
  function automatic logic [5:0] fn_terms(input logic [6*FW-1:0] sel, input itfd_func_e code);
    logic [5:0] hit;
    hit = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      hit[i] = (sel[i*FW +: FW] == code);
    end
    return hit;
  endfunction

  logic [11:0] mask_r;
  logic [6*FW-1:0] func_r;
  logic [3:0] cfg_r;
  itfd_drive_ctrl_s ctrl_r;
  itfd_drive_ctrl_s ctrl_nxt;
  itfd_bb_state_e bb_r;
  itfd_bb_state_e bb_nxt;
  logic [5:0] pins;
  logic [5:0] mask_eff;
  logic [5:0] term_act;
  logic [5:0] term_act_q_r;
  logic [5:0] term_ev;
  logic [CNT_W-1:0] cnt_r;
  logic [FREQ_W-1:0] freq_r;
  logic [31:0] ramp_cnt_r;
  logic shut_q_r;
  logic dp_wr_r;
  logic [5:0] dp_addr_r;
  logic [31:0] rdata_r;
  logic [6*FW-1:0] func_nxt;
  logic up_act;
  logic dn_act;
  logic up_ev;
  logic dn_ev;
  logic ramp_tick;
  logic step_up;
  logic step_dn;
  logic shut_act;
  logic bb_act;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign pins = {input_terminal_6, input_terminal_5, input_terminal_4,
                 input_terminal_3, input_terminal_2, input_terminal_1};

  // mask bits 0-2 forced open while commands come from terminals
  assign mask_eff = mask_r[5:0] &
    ((ctrl_r.cmd_src == ITFD_SRC_TERMINAL) ? ~`ITFD_WIRE_TERMS : 6'h3f);

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_term
      // closed contact pulls low; normally-closed inverts the sense
      assign term_act[g] = ~pins[g] ^ mask_eff[g];
      assign term_ev[g] = term_act[g] & ~term_act_q_r[g];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      term_act_q_r <= 6'h00;
    else
      term_act_q_r <= term_act;
  end

  // codes outside the decoded set match nothing
  assign up_act = |(term_act & fn_terms(func_r, ITFD_FN_FREQ_UP));
  assign dn_act = |(term_act & fn_terms(func_r, ITFD_FN_FREQ_DOWN));
  assign up_ev = |(term_ev & fn_terms(func_r, ITFD_FN_FREQ_UP));
  assign dn_ev = |(term_ev & fn_terms(func_r, ITFD_FN_FREQ_DOWN));
  assign bb_act = |(term_act & fn_terms(func_r, ITFD_FN_BASE_BLOCK));
  assign shut_act = |(term_act & fn_terms(func_r, ITFD_FN_SHUTOFF));

  // master frequency: step per edge, repeat while held
  assign ramp_tick = (ramp_cnt_r == 32'(RAMP_CYCLES - 1));
  assign step_up = ~dn_act & (up_ev | (up_act & ramp_tick));
  assign step_dn = ~up_act & (dn_ev | (dn_act & ramp_tick));

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ramp_cnt_r <= 32'h0;
    else if ((up_act == dn_act) || ramp_tick || up_ev || dn_ev)
      ramp_cnt_r <= 32'h0;
    else
      ramp_cnt_r <= ramp_cnt_r + 32'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      freq_r <= '0;
    else if (step_up)
      freq_r <= (freq_r >= FREQ_W'(`ITFD_FREQ_MAX - `ITFD_FREQ_STEP)) ?
                FREQ_W'(`ITFD_FREQ_MAX) : freq_r + FREQ_W'(`ITFD_FREQ_STEP);
    else if (step_dn)
      freq_r <= (freq_r <= FREQ_W'(`ITFD_FREQ_STEP)) ? '0 : freq_r - FREQ_W'(`ITFD_FREQ_STEP);
  end

  // internal counter
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cnt_r <= '0;
    else if (|(term_act & fn_terms(func_r, ITFD_FN_CNT_RESET)))
      cnt_r <= '0;
    else if (|(term_ev & fn_terms(func_r, ITFD_FN_CNT_TRIG) & ~`ITFD_LOW_TERMS))
      cnt_r <= cnt_r + CNT_W'(1);
  end

  // base block sequence
  always_comb
  begin
    bb_nxt = bb_r;
    case (bb_r)
      ITFD_BB_NORMAL:
        if (bb_act)
          bb_nxt = ITFD_BB_BLOCK;
      ITFD_BB_BLOCK:
        if (!bb_act)
          bb_nxt = ITFD_BB_SEARCH;
      ITFD_BB_SEARCH:
        if (bb_act)
          bb_nxt = ITFD_BB_BLOCK;
        else if (drive_state.speed_locked)
          bb_nxt = ITFD_BB_ACCEL;
      ITFD_BB_ACCEL:
        if (bb_act)
          bb_nxt = ITFD_BB_BLOCK;
        else if (drive_state.at_master_freq)
          bb_nxt = ITFD_BB_NORMAL;
      default:
        bb_nxt = ITFD_BB_BLOCK;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      bb_r <= ITFD_BB_NORMAL;
    else
      bb_r <= bb_nxt;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      shut_q_r <= 1'b0;
    else
      shut_q_r <= shut_act;
  end

  // drive control decode
  always_comb
  begin
    logic src_t;
    logic src_k;
    logic src_c;
    logic dir_fn;
    logic pump_auto;
    src_t = |(term_act & fn_terms(func_r, ITFD_FN_SRC_TERM));
    src_k = |(term_act & fn_terms(func_r, ITFD_FN_SRC_KEYPAD));
    src_c = |(term_act & fn_terms(func_r, ITFD_FN_SRC_COMM));
    dir_fn = |fn_terms(func_r, ITFD_FN_DIRECTION);
    pump_auto = |(term_act & fn_terms(func_r, ITFD_FN_PUMP_AUTO));
    ctrl_nxt = '0;
    ctrl_nxt.outputs_blocked = (bb_nxt == ITFD_BB_BLOCK) | shut_act;
    ctrl_nxt.speed_search = (bb_nxt == ITFD_BB_SEARCH);
    ctrl_nxt.accel_to_master = (bb_nxt == ITFD_BB_ACCEL);
    ctrl_nxt.restart_zero = shut_q_r & ~shut_act;
    ctrl_nxt.jog_req = |(term_act & fn_terms(func_r, ITFD_FN_JOG));
    ctrl_nxt.ext_fault = |(term_act & fn_terms(func_r, ITFD_FN_EXT_FAULT) &
                           ~`ITFD_LOW_TERMS);
    ctrl_nxt.pid_disable = |(term_act & fn_terms(func_r, ITFD_FN_PID_OFF));
    ctrl_nxt.param_lock = |(term_act & fn_terms(func_r, ITFD_FN_PARAM_LOCK));
    if (src_t)
      ctrl_nxt.cmd_src = ITFD_SRC_TERMINAL;
    else if (src_k)
      ctrl_nxt.cmd_src = ITFD_SRC_KEYPAD;
    else if (src_c)
      ctrl_nxt.cmd_src = ITFD_SRC_COMM;
    else
      ctrl_nxt.cmd_src = itfd_cmd_src_e'(cfg_r[`ITFD_CTRL_SRC_LSB +: 2]);
    ctrl_nxt.freq_src_second = |(term_act & fn_terms(func_r, ITFD_FN_FREQ_SRC2));
    ctrl_nxt.dir_override = dir_fn & ~cfg_r[`ITFD_CTRL_DIRCFG_BIT];
    ctrl_nxt.dir_reverse = ctrl_nxt.dir_override &
                           |(term_act & fn_terms(func_r, ITFD_FN_DIRECTION));
    ctrl_nxt.stop_fwd = drive_state.motor_running & ~drive_state.motor_reverse &
                        |(term_act & fn_terms(func_r, ITFD_FN_FWD_LIMIT));
    ctrl_nxt.stop_rev = drive_state.motor_running & drive_state.motor_reverse &
                        |(term_act & fn_terms(func_r, ITFD_FN_REV_LIMIT));
    ctrl_nxt.pump_auto = pump_auto;
    ctrl_nxt.pump_local_ctrl = ~pump_auto | cfg_r[`ITFD_CTRL_MASTER_BIT];
    ctrl_nxt.pump_follow_master = pump_auto & ~cfg_r[`ITFD_CTRL_MASTER_BIT];
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_r <= '0;
    else
      ctrl_r <= ctrl_nxt;
  end

  assign drive_ctrl = ctrl_r;
  assign counter_value = cnt_r;
  assign master_freq = freq_r;

  // ahb-lite: zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign addr_ok = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0);

  always_comb
  begin
    rd_mux = 32'h0;
    if (addr_ok)
    begin
      case (haddr[5:0])
        `ITFD_OFS_MASK: rd_mux = {20'h0, mask_r};
        `ITFD_OFS_FUNC: rd_mux = {2'h0, func_r};
        `ITFD_OFS_CTRL: rd_mux = {28'h0, cfg_r};
        `ITFD_OFS_STAT: rd_mux = 32'({term_act_q_r, ctrl_r});
        `ITFD_OFS_CNT: rd_mux = 32'(cnt_r);
        `ITFD_OFS_FREQ: rd_mux = 32'(freq_r);
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 6'h00;
      rdata_r <= 32'h0;
    end
    else if (hready)
    begin
      dp_wr_r <= hsel & htrans[1] & hwrite & addr_ok & (hsize == 3'h2);
      dp_addr_r <= haddr[5:0];
      if (hsel && htrans[1] && !hwrite)
        rdata_r <= rd_mux;
    end
  end

  // per-field filter on function assignments
  always_comb
  begin
    logic [FW-1:0] new_code;
    logic [FW-1:0] old_code;
    logic low_term;
    new_code = '0;
    old_code = '0;
    low_term = 1'b0;
    func_nxt = func_r;
    for (int i = 0; i < 6; i++)
    begin
      new_code = hwdata[i*FW +: FW];
      old_code = func_r[i*FW +: FW];
      low_term = LOW_TERMS[i];
      if (new_code == ITFD_FN_JOG && old_code != ITFD_FN_JOG &&
          (drive_state.motor_running || low_term))
        func_nxt[i*FW +: FW] = old_code;
      else if (low_term && (new_code == ITFD_FN_CNT_TRIG || new_code == ITFD_FN_EXT_FAULT))
        func_nxt[i*FW +: FW] = old_code;
      else
        func_nxt[i*FW +: FW] = new_code;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask_r <= `ITFD_MASK_RST;
      func_r <= `ITFD_FUNC_RST;
      cfg_r <= `ITFD_CTRL_RST;
    end
    else if (dp_wr_r && !ctrl_r.param_lock)
    begin
      case (dp_addr_r)
        `ITFD_OFS_MASK: mask_r <= hwdata[11:0];
        `ITFD_OFS_FUNC: func_r <= func_nxt;
        `ITFD_OFS_CTRL: cfg_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end

endmodule

`default_nettype wire

/* sim/itfd_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

module itfd_top_asserts
  import itfd_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int FREQ_W = 16
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // terminals
  input wire logic input_terminal_1,
  input wire logic input_terminal_2,
  input wire logic input_terminal_3,
  input wire logic input_terminal_4,
  input wire logic input_terminal_5,
  input wire logic input_terminal_6,
  // drive side
  input wire itfd_drive_state_s drive_state,
  input wire itfd_drive_ctrl_s drive_ctrl,
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic [FREQ_W-1:0] master_freq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_RDATA_HOLD: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_CNT_STEP: assert property (counter_value != $past(counter_value) |->
    counter_value == CNT_W'($past(counter_value) + 1) || counter_value == '0)
    else $error("counter moved by other than one");
  AST_FREQ_STEP: assert property (master_freq != $past(master_freq) |->
    master_freq == FREQ_W'($past(master_freq) + 1) || $past(master_freq) == FREQ_W'(master_freq + 1))
    else $error("frequency moved by other than one step");
  AST_FREQ_MAX: assert property (master_freq <= 16'hea60)
    else $error("frequency above maximum");
  AST_SEARCH_START: assert property ($rose(drive_ctrl.speed_search) |->
    $past(drive_ctrl.outputs_blocked))
    else $error("speed search without prior block");
  AST_SEARCH_END: assert property (drive_ctrl.speed_search && drive_state.speed_locked |->
    ##[1:2] !drive_ctrl.speed_search)
    else $error("speed search kept after lock");
  AST_ACCEL_END: assert property (drive_ctrl.accel_to_master && drive_state.at_master_freq |->
    ##[1:2] !drive_ctrl.accel_to_master)
    else $error("acceleration kept at master frequency");
  AST_RESTART_PULSE: assert property (drive_ctrl.restart_zero |->
    !$past(drive_ctrl.restart_zero) && $past(drive_ctrl.outputs_blocked))
    else $error("restart pulse malformed");
  AST_PUMP_ONE: assert property ($past(rst_b) |->
    drive_ctrl.pump_local_ctrl ^ drive_ctrl.pump_follow_master)
    else $error("pump control not exactly one mode");
  AST_SRC_LEGAL: assert property (drive_ctrl.cmd_src != 2'h3)
    else $error("illegal command source");

  COV_SEARCH: cover property (drive_ctrl.speed_search ##[1:4] drive_ctrl.accel_to_master);
  COV_RESTART: cover property (drive_ctrl.restart_zero);
  COV_COUNT: cover property (counter_value == 16'h0003);
endmodule

bind itfd_top itfd_top_asserts #(.CNT_W(CNT_W), .FREQ_W(FREQ_W)) u_asserts (
  .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .input_terminal_1(input_terminal_1),
  .input_terminal_2(input_terminal_2), .input_terminal_3(input_terminal_3),
  .input_terminal_4(input_terminal_4), .input_terminal_5(input_terminal_5),
  .input_terminal_6(input_terminal_6), .drive_state(drive_state), .drive_ctrl(drive_ctrl),
  .counter_value(counter_value), .master_freq(master_freq));

`default_nettype wire

/* sim/itfd_contacts.sv */
`timescale 1ns/100ps
`default_nettype none

module itfd_contacts
(
  // contact state
  input wire logic [5:0] closed,
  // pins, pulled up while open
  output logic [5:0] pin
);
  // closing pulls the pin low, a falling edge
  assign pin = ~closed;
endmodule

`default_nettype wire

/* sim/itfd_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_eq(32'(g), 32'(e))

module itfd_tb_top
  import itfd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [5:0] closed = 6'h00;
  logic [5:0] pin;
  logic seen;
  itfd_drive_state_s ds = '0;
  itfd_drive_ctrl_s dc;
  logic [15:0] cnt;
  logic [15:0] freq;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [4:0] codes [11] = '{5'h0e, 5'h0f, 5'h11, 5'h16, 5'h15, 5'h12, 5'h14, 5'h08, 5'h17,
    5'h18, 5'h19};
  int bits [11] = '{12, 11, 10, 7, 5, 8, 9, 13, 4, 3, 0};
  logic [3:0] sts [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'hc, 4'h0};

  always #5 clk_sys = ~clk_sys;

  itfd_contacts i_contacts (.closed(closed), .pin(pin));

  itfd_top #(.RAMP_CYCLES(4)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .input_terminal_1(pin[0]), .input_terminal_2(pin[1]),
    .input_terminal_3(pin[2]), .input_terminal_4(pin[3]), .input_terminal_5(pin[4]),
    .input_terminal_6(pin[5]), .drive_state(ds), .drive_ctrl(dc), .counter_value(cnt),
    .master_freq(freq));

  task automatic tally_and_finish();
    $display("Summary: %0d checks, %0d errors", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // address phase held until ready, then data phase until ready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [31:0] a);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic setfn(input int t, input logic [4:0] c);
    wr(32'h4, 32'(c) << (5 * t));
  endtask

  // settle after the edge before looking
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse(input int t);
    closed[t] <= 1'b1;
    tick(2);
    closed[t] <= 1'b0;
    tick(2);
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    tick(10);
    rst_b <= 1'b1;
    tick(2);
    `CHK(dc, 18'h00002);
    `CHK({hready, hresp}, 2'h2);
    for (int a = 0; a <= 8; a += 4)
    begin
      rd(32'(a));
      `CHK(q, 32'h0);
    end
    rd(32'h20);
    `CHK(q, 32'h0);
    wr(32'h4, 32'h000021cc);
    rd(32'h4);
    `CHK(q, 32'h00002000);
    ds <= 4'h8;
    wr(32'h4, 32'h00042000);
    rd(32'h4);
    `CHK(q, 32'h00002000);
    ds <= 4'h0;
    wr(32'h4, 32'h0006b000);
    repeat (3) pulse(2);
    `CHK(cnt, 16'h0003);
    closed[3] <= 1'b1;
    tick(2);
    `CHK(cnt, 16'h0000);
    pulse(2);
    `CHK(cnt, 16'h0000);
    closed[3] <= 1'b0;
    pulse(2);
    rd(32'h10);
    `CHK(q, 32'h1);
    wr(32'h0, 32'h4);
    tick(2);
    `CHK(cnt, 16'h0002);
    pulse(2);
    `CHK(cnt, 16'h0003);
    wr(32'h8, 32'h1);
    wr(32'h0, 32'h7);
    rd(32'hc);
    `CHK(q[23:18], 6'h00);
    `CHK(q[9:8], 2'h1);
    wr(32'h8, 32'h0);
    // status terminal bits lag the source change by two edges
    tick(2);
    rd(32'hc);
    `CHK(q[23:18], 6'h07);
    wr(32'h0, 32'h0);
    wr(32'h4, 32'h20900000);
    closed[4] <= 1'b1;
    tick(2);
    `CHK(dc.outputs_blocked, 1'b1);
    closed[4] <= 1'b0;
    tick(2);
    `CHK(dc.speed_search, 1'b1);
    ds <= 4'h2;
    tick(3);
    `CHK({dc.speed_search, dc.accel_to_master}, 2'h1);
    ds <= 4'h3;
    tick(3);
    `CHK({dc.outputs_blocked, dc.accel_to_master}, 2'h0);
    ds <= 4'h0;
    closed[5] <= 1'b1;
    tick(2);
    `CHK(dc.outputs_blocked, 1'b1);
    seen = 1'b0;
    closed[5] <= 1'b0;
    repeat (3)
    begin
      tick(1);
      seen = seen | dc.restart_zero;
    end
    `CHK(seen, 1'b1);
    wr(32'h4, 32'h0000016a);
    pulse(0);
    `CHK(freq, 16'h0001);
    closed[0] <= 1'b1;
    tick(10);
    closed[0] <= 1'b0;
    tick(2);
    `CHK(freq, 16'h0004);
    closed[1:0] <= 2'h3;
    tick(10);
    closed[1:0] <= 2'h0;
    tick(2);
    `CHK(freq, 16'h0004);
    pulse(1);
    `CHK(freq, 16'h0003);
    foreach (codes[i])
    begin
      ds <= sts[i];
      setfn(3, codes[i]);
      closed[3] <= 1'b1;
      tick(2);
      `CHK(dc[bits[i]], 1'b1);
      closed[3] <= 1'b0;
      tick(2);
      `CHK(dc[bits[i]], 1'b0);
    end
    // pump master with direction config set: local control, no override
    wr(32'h8, 32'hc);
    wr(32'h4, 32'h000cd400);
    closed[3:2] <= 2'h3;
    tick(2);
    `CHK(dc[6:0], 7'h06);
    closed[3:2] <= 2'h0;
    tick(2);
    wr(32'h8, 32'h2);
    setfn(3, 5'h13);
    closed[3] <= 1'b1;
    tick(2);
    `CHK(dc.cmd_src, 2'h0);
    closed[3] <= 1'b0;
    tick(2);
    `CHK(dc.cmd_src, 2'h2);
    wr(32'h8, 32'h0);
    setfn(3, 5'h11);
    closed[3] <= 1'b1;
    tick(2);
    wr(32'h0, 32'h3f);
    closed[3] <= 1'b0;
    tick(2);
    rd(32'h0);
    `CHK(q, 32'h0);
    wr(32'h4, 32'h3fffffff);
    closed <= 6'h3f;
    tick(2);
    `CHK(dc, 18'h00002);
    `CHK(freq, 16'h0003);
    closed <= 6'h00;
    tick(2);
    tally_and_finish();
  end
endmodule

`default_nettype wire
